// [sram_port_pkg.sv]
// Shared constants and carrier types of the pipelined burst memory port
package sram_port_pkg;

  localparam int ADDR_W = 8;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_PTR_W = 5;

  // Two cycles to enter or leave sleep
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLEEP_CYCLES = 2;
  localparam logic [1:0] SLEEP_CNT_MAX = 2'h2;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;

  localparam logic BURST_LINEAR = 1'b0;
  localparam logic [1:0] BURST_STEP_ONE = 2'h1;

  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_ENTER,
    ST_ASLEEP,
    ST_LEAVE
  } sleep_st_t;

  // Sampled bus controls, address and write data, one clock edge's worth
  typedef struct packed {
    logic cpu_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_gate_n;
    logic [LANES-1:0] lane_write_select_n;
    logic chip_select_primary_n;
    logic chip_select_depth_hi;
    logic chip_select_depth_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_in_t;

endpackage

// [data_fifo.sv]
// Parameterised valid/ready FIFO for read data
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32,
  parameter int PTR_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count != (PTR_W+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// [pipelined_burst_sram_port.sv]
// Pipelined burst static memory front end with sleep control and read FIFO
`timescale 1ns/1ps
// Overview of operation
// - All synchronous inputs registered; read data leaves through an output register.
// - Read starts on strobe low, all selects active, global and gate writes high.
// - Strobed access loads address into address register and burst counter.
// - Read data appears two edges after the strobe is sampled, only while output enable is low.
// - First cycle after leaving deselect keeps data outputs off.
// - Strobed deselect turns outputs off at once; back-to-back reads work.
// - Processor strobe is ignored while primary chip select is high.
// - Both strobes low: only the processor strobe is acted upon, unless primary chip select is high, when the controller strobe acts.
// - Processor-strobe write takes two clocks; first cycle ignores write and advance.
// - Second edge of processor-strobe write commits data with controls then sampled.
// - Low global write stores all lanes; otherwise gate and lane selects decide.
// - Gated byte write updates selected lanes only; others keep contents.
// - Controller-strobe write completes in one clock with a write combination.
// - Controller-strobe write cycle ignores the burst advance input.
// - Any detected write cycle turns the data drivers off regardless of enable.
// - Two-bit wraparound burst counter loaded from the two lowest address bits.
// - Strap low selects linear order, high or floating selects interleaved.
// - Low advance steps the burst counter; bursts for reads and writes.
// - Advance high without strobes repeats access at the current burst address.
// - Interleaved order: start bits XOR step count.
// - Linear order: start bits plus step count modulo four.
// - Sleep input gives data-keeping low power; entry and exit take two clocks.
// - Access pending at sleep entry is dropped as invalid.
module pipelined_burst_sram_port
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [sram_port_pkg::LANES-1:0] lane_write_select_n,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_depth_hi,
  input wire logic chip_select_depth_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  input wire logic [sram_port_pkg::ADDR_W-1:0] addr,
  input wire logic [sram_port_pkg::DATA_W-1:0] dq_in,
  output logic [sram_port_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic sleeping,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [sram_port_pkg::DATA_W-1:0] rd_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_in_t bus;
    logic oe_n_s1;
    logic oe_n_s2;
    logic sleep_s1;
    logic sleep_s2;
    logic strap_s1;
    logic strap_s2;
    logic linear;
    logic strap_taken;
    logic [ADDR_W-1:0] base;
    logic [1:0] start;
    logic [1:0] step;
    logic active;
    logic wr_pending;
    logic rd_fresh;
    logic first_cycle;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
    sleep_st_t sleep_st;
    logic [1:0] sleep_cnt;
    logic sleeping;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rdata;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [DATA_W-1:0] mem_wd;
  logic [LANES-1:0] mem_lane;
  logic fifo_in_ready;
  logic fifo_push;

  // Burst address from base, start bits and step count
  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] b,
                                                   input logic [1:0] s,
                                                   input logic [1:0] n,
                                                   input logic lin);
    logic [1:0] low;
    low = lin ? 2'(s + n) : (s ^ n);
    return {b[ADDR_W-1:2], low};
  endfunction

  // Lane mask from sampled write controls; zero means no write
  function automatic logic [LANES-1:0] lane_mask(input bus_in_t b);
    if (!b.global_write_n) begin
      return '1;
    end else if (!b.byte_write_gate_n) begin
      return ~b.lane_write_select_n;
    end
    return '0;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic selected;
    logic cpu_go;
    logic ctrl_go;
    logic deselect;
    logic [LANES-1:0] mask;
    logic [ADDR_W-1:0] acc_addr;
    logic is_read;
    logic awake;
    selected = 1'b0;
    cpu_go = 1'b0;
    ctrl_go = 1'b0;
    deselect = 1'b0;
    mask = '0;
    acc_addr = '0;
    is_read = 1'b0;
    awake = 1'b0;
    next_cur = cur;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    mem_lane = '0;

    // Pins sampled on the rising edge; async pins through two flops
    next_cur.bus = '{cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
                     global_write_n, byte_write_gate_n, lane_write_select_n,
                     chip_select_primary_n, chip_select_depth_hi,
                     chip_select_depth_n, addr, dq_in};
    next_cur.oe_n_s1 = output_enable_n;
    next_cur.oe_n_s2 = cur.oe_n_s1;
    next_cur.sleep_s1 = sleep_request;
    next_cur.sleep_s2 = cur.sleep_s1;
    next_cur.strap_s1 = burst_order_strap;
    next_cur.strap_s2 = cur.strap_s1;
    // Strap caught once after reset release, then frozen
    if (!cur.strap_taken) begin
      next_cur.linear = (cur.strap_s2 == BURST_LINEAR);
      next_cur.strap_taken = 1'b1;
    end

    // Sleep sequencer: two cycles each way
    unique case (cur.sleep_st)
      ST_AWAKE: begin
        if (cur.sleep_s2) begin
          next_cur.sleep_st = ST_ENTER;
          next_cur.sleep_cnt = SLEEP_CNT_RST;
          next_cur.active = 1'b0;
          next_cur.wr_pending = 1'b0;
        end
      end
      ST_ENTER: begin
        next_cur.sleep_cnt = cur.sleep_cnt + 1'b1;
        if (cur.sleep_cnt + 1'b1 == SLEEP_CNT_MAX) begin
          next_cur.sleep_st = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (!cur.sleep_s2) begin
          next_cur.sleep_st = ST_LEAVE;
          next_cur.sleep_cnt = SLEEP_CNT_RST;
        end
      end
      ST_LEAVE: begin
        next_cur.sleep_cnt = cur.sleep_cnt + 1'b1;
        if (cur.sleep_cnt + 1'b1 == SLEEP_CNT_MAX) begin
          next_cur.sleep_st = ST_AWAKE;
        end
      end
    endcase
    awake = (cur.sleep_st == ST_AWAKE) && !cur.sleep_s2;
    next_cur.sleeping = (next_cur.sleep_st != ST_AWAKE);

    // Decode the edge sampled in the previous cycle
    selected = !cur.bus.chip_select_primary_n && cur.bus.chip_select_depth_hi &&
               !cur.bus.chip_select_depth_n;
    cpu_go = !cur.bus.cpu_addr_strobe_n && !cur.bus.chip_select_primary_n;
    ctrl_go = !cur.bus.ctrl_addr_strobe_n && !cpu_go;
    mask = lane_mask(cur.bus);
    next_cur.rd_fresh = 1'b0;

    if (awake) begin
      if ((cpu_go || ctrl_go) && !selected) begin
        next_cur.active = 1'b0;
        next_cur.wr_pending = 1'b0;
        next_cur.first_cycle = 1'b0;
      end else if (cpu_go || ctrl_go) begin
        next_cur.base = cur.bus.addr;
        next_cur.start = cur.bus.addr[1:0];
        next_cur.step = '0;
        next_cur.first_cycle = !cur.active;
        next_cur.active = 1'b1;
        acc_addr = cur.bus.addr;
        if (cpu_go) begin
          // Always a read first; write controls wait for the next edge
          is_read = 1'b1;
          next_cur.wr_pending = 1'b1;
        end else if (mask != '0) begin
          mem_we = 1'b1;
          next_cur.wr_pending = 1'b0;
        end else begin
          is_read = 1'b1;
          next_cur.wr_pending = 1'b0;
        end
      end else if (cur.active) begin
        next_cur.first_cycle = 1'b0;
        // Second edge of a processor-strobed write uses the current address
        if (!cur.wr_pending && !cur.bus.burst_step_n) begin
          next_cur.step = cur.step + BURST_STEP_ONE;
        end
        next_cur.wr_pending = 1'b0;
        acc_addr = burst_addr(cur.base, cur.start, next_cur.step, cur.linear);
        if (mask != '0) begin
          mem_we = 1'b1;
        end else begin
          is_read = 1'b1;
        end
      end
    end
    mem_wa = acc_addr;
    mem_wd = cur.bus.wdata;
    mem_lane = mask;
    next_cur.rd_fresh = is_read;

    // Output register: data one edge after the access
    if (cur.rd_fresh) begin
      next_cur.dq_out = rdata;
    end
    next_cur.dq_oe_n = !(cur.rd_fresh && !cur.first_cycle && !cur.oe_n_s2 &&
                         awake && !mem_we);

    if (!rst_n) begin
      next_cur = '0;
      // Strap synchroniser keeps running so the order is settled at release
      next_cur.strap_s1 = burst_order_strap;
      next_cur.strap_s2 = cur.strap_s1;
      next_cur.oe_n_s1 = 1'b1;
      next_cur.oe_n_s2 = 1'b1;
      next_cur.dq_oe_n = 1'b1;
      next_cur.sleep_st = ST_AWAKE;
      next_cur.sleep_cnt = SLEEP_CNT_RST;
      mem_we = 1'b0;
      next_cur.rd_fresh = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Storage array with per-lane write
  // ----------------------------------------------------------------
  // One process owns the whole array, so no lane slice has a second driver
  always_ff @(posedge clk) begin
    for (int lane = 0; lane < LANES; lane++) begin
      if (mem_we && mem_lane[lane]) begin
        mem[mem_wa][lane*LANE_W +: LANE_W] <= mem_wd[lane*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[mem_wa];
    cur <= next_cur;
  end

  // Read data also streams out through the FIFO; a stalled drain simply drops
  // words, since the memory bus itself cannot be held off
  assign fifo_push = cur.rd_fresh && fifo_in_ready && rst_n;

  data_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .PTR_W(FIFO_PTR_W)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(rdata),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign dq_out = cur.dq_out;
  assign dq_oe_n = cur.dq_oe_n;
  assign sleeping = cur.sleeping;

endmodule

// [sram_port_sva.sv]
// Pin-level assertions for the burst memory port
`timescale 1ns/1ps
module sram_port_sva
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic global_write_n,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_depth_hi,
  input wire logic chip_select_depth_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic dq_oe_n,
  input wire logic sleeping,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [sram_port_pkg::DATA_W-1:0] rd_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic sel;
  assign sel = !chip_select_primary_n && chip_select_depth_hi && !chip_select_depth_n;
  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_n |=> dq_oe_n && !sleeping && !rd_valid) else $error("outputs active in reset");
  write_drivers_off_a: assert property (
    !ctrl_addr_strobe_n && cpu_addr_strobe_n && sel && !global_write_n |-> ##3 dq_oe_n)
    else $error("data driven in write cycle");
  deselect_off_a: assert property (
    !ctrl_addr_strobe_n && chip_select_primary_n |-> ##[2:3] dq_oe_n)
    else $error("data driven after deselect");
  enable_off_a: assert property (output_enable_n [*5] |-> dq_oe_n)
    else $error("data driven with enable high");
  sleep_enter_a: assert property (sleep_request [*6] |-> sleeping)
    else $error("sleep not entered");
  sleep_exit_a: assert property (!sleep_request [*8] |-> !sleeping)
    else $error("sleep not left");
  sleep_quiet_a: assert property (sleeping && $past(sleeping) |-> dq_oe_n)
    else $error("data driven while asleep");
  fifo_hold_a: assert property (
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data)) else $error("fifo output moved");
endmodule
bind pipelined_burst_sram_port sram_port_sva sram_port_sva_inst (.clk, .rst_n,
  .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .global_write_n, .chip_select_primary_n,
  .chip_select_depth_hi, .chip_select_depth_n, .output_enable_n, .sleep_request,
  .dq_oe_n, .sleeping, .rd_valid, .rd_ready, .rd_data);

// [bus_driver_model.sv]
// Far-end bus master model driving the memory port pins
`timescale 1ns/1ps
module bus_driver_model
  import sram_port_pkg::*;
(
  input wire logic clk,
  output sram_port_pkg::bus_in_t bus,
  output logic oe_n,
  output logic sleep_req
);
  initial begin
    bus = '1;
    oe_n = 1'b1;
    sleep_req = 1'b0;
  end
  // c = {select, cpu strobe, ctrl strobe, step, global write, gate}, strobes active low
  task automatic cycle(input logic [5:0] c, input logic [3:0] ln, input logic [7:0] a,
                       input logic [35:0] d);
    @(negedge clk);
    bus.chip_select_primary_n = !c[5];
    bus.chip_select_depth_hi = c[5];
    bus.chip_select_depth_n = !c[5];
    {bus.cpu_addr_strobe_n, bus.ctrl_addr_strobe_n, bus.burst_step_n} = c[4:2];
    {bus.global_write_n, bus.byte_write_gate_n} = c[1:0];
    bus.lane_write_select_n = ln;
    bus.addr = a;
    // Released lines flip so stale data cannot pass as written data
    bus.wdata = (&c[1:0]) ? ~bus.wdata : d;
  endtask
  task automatic set_oe(input logic v);
    oe_n = v;
    repeat (3) cycle(6'h1F, 4'hF, bus.addr, bus.wdata);
  endtask
  task automatic nap(input int n);
    cycle(6'h17, 4'hF, bus.addr, bus.wdata);
    cycle(6'h1F, 4'hF, bus.addr, bus.wdata);
    sleep_req = 1'b1;
    repeat (n) @(negedge clk);
    sleep_req = 1'b0;
    repeat (4) cycle(6'h1F, 4'hF, bus.addr, bus.wdata);
  endtask
endmodule

// [test_pipelined_burst_sram_port.sv]
// Self-checking bench for the pipelined burst memory port
`timescale 1ns/1ps
`define CMP(a, b, m) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED at %0t: %s", $time, m); end end
module test_pipelined_burst_sram_port;
  import sram_port_pkg::*;
  typedef struct {int due; logic [DATA_W-1:0] v; logic [1:0] o;} exp_t;
  logic clk, rst_n, oe_n, slp, strap, rd_ready, dq_oe_n, sleeping, rd_valid;
  bus_in_t bus;
  logic [DATA_W-1:0] dq_out, rd_data, d;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] a;
  logic [3:0] ln;
  exp_t q[$];
  int fails, total_checks, ecnt;
  bus_driver_model bus_driver_model_inst (.clk, .bus, .oe_n, .sleep_req(slp));
  pipelined_burst_sram_port pipelined_burst_sram_port_inst (.clk, .rst_n,
    .cpu_addr_strobe_n(bus.cpu_addr_strobe_n), .ctrl_addr_strobe_n(bus.ctrl_addr_strobe_n),
    .burst_step_n(bus.burst_step_n), .global_write_n(bus.global_write_n),
    .byte_write_gate_n(bus.byte_write_gate_n), .lane_write_select_n(bus.lane_write_select_n),
    .chip_select_primary_n(bus.chip_select_primary_n), .addr(bus.addr), .dq_in(bus.wdata),
    .chip_select_depth_hi(bus.chip_select_depth_hi), .burst_order_strap(strap),
    .chip_select_depth_n(bus.chip_select_depth_n), .output_enable_n(oe_n),
    .sleep_request(slp), .dq_out, .dq_oe_n, .sleeping, .rd_valid, .rd_ready, .rd_data);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) ecnt++;
  // o[1] asks for a drive check, o[0] is the expected drive-off level
  always @(negedge clk) begin
    rd_ready = 1'($urandom);
    while (q.size() > 0 && q[0].due == ecnt) begin
      `CMP(dq_out, q[0].v, "read data")
      if (q[0].o[1]) `CMP(dq_oe_n, q[0].o[0], "drive state")
      void'(q.pop_front());
    end
  end
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
                                               input logic [3:0] m);
    for (int g = 0; g < LANES; g++)
      if (!m[g]) o[g*LANE_W +: LANE_W] = n[g*LANE_W +: LANE_W];
    return o;
  endfunction
  function automatic logic [ADDR_W-1:0] nb(input logic [ADDR_W-1:0] b, input int k);
    return {b[ADDR_W-1:2], strap ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)};
  endfunction
  task automatic go(input logic [5:0] c, input logic [ADDR_W-1:0] ad);
    d = DATA_W'({$urandom, $urandom});
    bus_driver_model_inst.cycle(c, ln, ad, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [1:0] o);
    // Data reaches the output register two edges after its sampling edge
    q.push_back('{ecnt + 3, mem[ad], o});
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    strap = 1'b1;
    rd_ready = 1'b1;
    ln = 4'hF;
    void'($urandom(97357));
    for (int s = 1; s >= 0; s--) begin
      strap = s[0];
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      `CMP(rd_valid, 1'b0, "read stream not empty after reset")
      `CMP(dq_oe_n, 1'b1, "data driven after reset")
      bus_driver_model_inst.set_oe(1'b1);
      for (int i = 0; i < DEPTH; i++) begin
        go(6'h35, ADDR_W'(i));
        mem[i] = d;
      end
      for (int i = 0; i < 8; i++) begin
        ln = 4'($urandom) & 4'hE;
        a = ADDR_W'($urandom);
        go(6'h36, a);
        mem[a] = merge(mem[a], d, ln);
      end
      ln = 4'hF;
      a = ADDR_W'($urandom);
      go(6'h2D, a);
      rd(a, 2'b01);
      go(6'h1D, ~a);
      mem[a] = d;
      go(6'h35, a);
      mem[a] = d;
      go(6'h19, ~a);
      mem[nb(a, 1)] = d;
      bus_driver_model_inst.set_oe(1'b0);
      go(6'h17, a);
      go(6'h37, a);
      rd(a, 2'b11);
      go(6'h37, ~a);
      rd(~a, 2'b10);
      go(6'h17, a);
      go(6'h25, a);
      rd(a, 2'b11);
      go(6'h37, a);
      rd(a, 2'b10);
      for (int k = 1; k < 4; k++) begin
        go(6'h1B, ~a);
        rd(nb(a, k), 2'b10);
      end
      go(6'h1F, ~a);
      rd(nb(a, 3), 2'b01);
      for (int i = 0; i < 24; i++) begin
        a = ADDR_W'($urandom);
        go(6'h37, a);
        rd(a, 2'b01);
      end
      bus_driver_model_inst.nap(8);
      `CMP(sleeping, 1'b1, "sleep left too early")
      go(6'h37, a);
      `CMP(sleeping, 1'b0, "sleep not left in time")
      rd(a, 2'b01);
      repeat (6) go(6'h1F, a);
    end
    complete_run();
  end
endmodule
